/* File: shared/wfld_map.vh */
`ifndef WFLD_MAP_VH
`define WFLD_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define WFLD_OFS_CFG3        8'h00
`define WFLD_OFS_COMPANION   8'h04
`define WFLD_OFS_NODE_LO     8'h08
`define WFLD_OFS_NODE_HI     8'h0C
`define WFLD_OFS_STATUS      8'h10
`define WFLD_OFS_CLEAR       8'h14
`define WFLD_OFS_ENABLE      8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WFLD_CFG3_PATTERN    5
`define WFLD_CFG3_LINK       4
`define WFLD_CFG3_FBB        0
`define WFLD_COMP_PWE        0
`define WFLD_EVT_PATTERN     0
`define WFLD_EVT_LINK        1

// ----------------------------------------------------------------------------
// Reset values and frame geometry
// ----------------------------------------------------------------------------
`define WFLD_CFG3_RST        2'h0
`define WFLD_COMP_RST        1'h0
`define WFLD_NODE_RST        48'h000000000000
`define WFLD_EVT_RST         2'h0
`define WFLD_SYNC_BYTE       8'hFF
`define WFLD_SYNC_LEN        3'h6
`define WFLD_ID_LEN          3'h6
`define WFLD_ID_REPS         5'h10
`define WFLD_HDR_LEN         4'hC

`endif

/* File: design/wfld_pattern_scan.v */
`timescale 1ns/1ps
`include "wfld_map.vh"

// Hunts for the sync run and the sixteen identifier copies in a byte stream
module wfld_pattern_scan (
	clk,
	rst_n,
	frame_start,
	byte_valid,
	byte_data,
	node_id,
	found
);
	input  wire        clk;           // System clock
	input  wire        rst_n;         // Asynchronous reset, active low
	input  wire        frame_start;   // Clears the search for a new frame
	input  wire        byte_valid;    // Payload byte present
	input  wire [7:0]  byte_data;     // Payload byte
	input  wire [47:0] node_id;       // Station identifier, first byte in [47:40]
	output wire        found;         // Full sequence seen in this frame

	// ------------------------------------------------------------------------
	// Search state
	// ------------------------------------------------------------------------
	reg  [2:0] sync_cnt_ff;          // Sync bytes seen, saturates at six
	reg  [2:0] id_pos_ff;            // Byte index within one identifier copy
	reg  [4:0] rep_cnt_ff;           // Identifier copies completed
	reg        in_id_ff;             // Inside the identifier copies
	reg        found_ff;             // Sticky until the next frame
	reg  [2:0] nxt_sync_cnt;
	reg  [2:0] nxt_id_pos;
	reg  [4:0] nxt_rep_cnt;
	reg        nxt_in_id;
	reg        nxt_found;
	wire       is_sync;              // Byte equals the sync value

	assign found   = found_ff;
	assign is_sync = (byte_data == `WFLD_SYNC_BYTE);

	// Selects identifier byte by position, first transmitted byte first
	function [7:0] id_byte;
		input [47:0] id;
		input [2:0]  pos;
		begin
			case (pos)
				3'h0: id_byte = id[47:40];
				3'h1: id_byte = id[39:32];
				3'h2: id_byte = id[31:24];
				3'h3: id_byte = id[23:16];
				3'h4: id_byte = id[15:8];
				default: id_byte = id[7:0];
			endcase
		end
	endfunction

	// ------------------------------------------------------------------------
	// Next-state search logic
	// ------------------------------------------------------------------------
	always @* begin
		nxt_sync_cnt = sync_cnt_ff;
		nxt_id_pos   = id_pos_ff;
		nxt_rep_cnt  = rep_cnt_ff;
		nxt_in_id    = in_id_ff;
		nxt_found    = found_ff;
		if (frame_start) begin
			// A new frame drops any partial match
			nxt_sync_cnt = 3'h0;
			nxt_id_pos   = 3'h0;
			nxt_rep_cnt  = 5'h00;
			nxt_in_id    = 1'b0;
			nxt_found    = 1'b0;
		end else if (byte_valid && !found_ff) begin
			// Searched at every payload position, not a fixed offset
			if (in_id_ff && byte_data == id_byte(node_id, id_pos_ff)) begin
				if (id_pos_ff == `WFLD_ID_LEN - 3'h1) begin
					nxt_id_pos  = 3'h0;
					nxt_rep_cnt = rep_cnt_ff + 5'h01;
					if (rep_cnt_ff == `WFLD_ID_REPS - 5'h01)
						nxt_found = 1'b1;
				end else begin
					nxt_id_pos = id_pos_ff + 3'h1;
				end
			end else if (!in_id_ff && sync_cnt_ff == `WFLD_SYNC_LEN &&
				byte_data == id_byte(node_id, 3'h0)) begin
				// Copies start only right after six sync bytes
				nxt_in_id   = 1'b1;
				nxt_id_pos  = 3'h1;
				nxt_rep_cnt = 5'h00;
			end else begin
				// Breaking byte restarts the hunt and may itself open a run
				nxt_in_id   = 1'b0;
				nxt_id_pos  = 3'h0;
				nxt_rep_cnt = 5'h00;
				if (is_sync) begin
					if (in_id_ff)
						nxt_sync_cnt = 3'h1;
					else if (sync_cnt_ff != `WFLD_SYNC_LEN)
						nxt_sync_cnt = sync_cnt_ff + 3'h1;
				end else begin
					nxt_sync_cnt = 3'h0;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_cnt_ff <= 3'h0;
			id_pos_ff   <= 3'h0;
			rep_cnt_ff  <= 5'h00;
			in_id_ff    <= 1'b0;
			found_ff    <= 1'b0;
		end else begin
			sync_cnt_ff <= nxt_sync_cnt;
			id_pos_ff   <= nxt_id_pos;
			rep_cnt_ff  <= nxt_rep_cnt;
			in_id_ff    <= nxt_in_id;
			found_ff    <= nxt_found;
		end
	end

endmodule // wfld_pattern_scan

/* File: design/wfld_top.v */
`timescale 1ns/1ps
`include "wfld_map.vh"

module wfld_top (
	pclk,
	presetn,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	rx_valid,
	rx_data,
	rx_sof,
	rx_eof,
	rx_crc_ok,
	link_up_pin,
	pm_state_ok,
	back_to_back_in,
	power_event_out_n,
	irq
);
	input  wire        pclk;              // System clock, 200 MHz
	input  wire        presetn;           // Asynchronous reset, active low
	input  wire        psel;              // APB select
	input  wire        penable;           // APB access phase
	input  wire        pwrite;            // APB direction
	input  wire [7:0]  paddr;             // APB byte address
	input  wire [31:0] pwdata;            // APB write data
	output wire [31:0] prdata;            // APB read data
	output wire        pready;            // APB ready
	output wire        pslverr;           // APB error on unmapped address
	input  wire        rx_valid;          // Receive byte strobe
	input  wire [7:0]  rx_data;           // Receive byte
	input  wire        rx_sof;            // First byte of a frame
	input  wire        rx_eof;            // Frame end, CRC verdict valid
	input  wire        rx_crc_ok;         // Frame check sequence good
	input  wire        link_up_pin;       // Cable link status from the PHY
	input  wire        pm_state_ok;       // Device in a wake-capable power state
	input  wire        back_to_back_in;   // Fast back-to-back enable from PCI side
	output wire        power_event_out_n; // Power management event, active low
	output wire        irq;               // Level interrupt

	// ------------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------------
	reg  [1:0]  cfg3_ff;                  // [1] pattern wake, [0] link wake
	reg         pwe_ff;                   // Global wake enable
	reg  [47:0] node_id_ff;               // Station identifier
	reg  [1:0]  status_ff;                // Sticky wake events
	reg  [1:0]  int_en_ff;                // Interrupt enables
	reg         fbb_ff;                   // Registered back-to-back enable
	reg  [31:0] prdata_ff;
	reg         pready_ff;
	reg         pslverr_ff;
	reg         pme_n_ff;
	reg         irq_ff;

	// ------------------------------------------------------------------------
	// Receive path state
	// ------------------------------------------------------------------------
	reg  [3:0]  byte_idx_ff;              // Header byte counter, saturates
	reg         dst_own_ff;               // Destination still equals node id
	reg         dst_mcast_ff;             // Destination group bit set
	reg         in_frame_ff;              // Between start and end of a frame
	reg         link_meta_ff;             // First synchroniser stage
	reg         link_sync_ff;             // Second synchroniser stage
	reg         link_prev_ff;             // Previous synchronised level
	reg         pm_meta_ff;
	reg         pm_sync_ff;

	wire        apb_access;               // Completing access edge
	wire        apb_write;
	wire        mapped;                   // Address decodes to a register
	wire        armed_pattern;            // Pattern wake may fire
	wire        armed_link;               // Link wake may fire
	wire        payload_byte;             // Byte after both addresses
	wire        pattern_found;            // Scanner verdict
	wire        frame_ok;                 // Frame qualifies as a wake frame
	wire        link_rise;                // Link has come back
	wire [1:0]  events;                   // Hardware set requests
	wire [1:0]  clr_req;                  // Software clear requests
	wire [7:0]  cfg3_rd;                  // Read view of wake config
	reg  [7:0]  id_exp;                   // Expected destination byte
	reg  [31:0] rd_mux;

	assign prdata            = prdata_ff;
	assign pready            = pready_ff;
	assign pslverr           = pslverr_ff;
	assign power_event_out_n = pme_n_ff;
	assign irq               = irq_ff;

	// ------------------------------------------------------------------------
	// Wake arming
	// ------------------------------------------------------------------------
	// Both enables are only live under the global enable
	assign armed_pattern = cfg3_ff[1] & pwe_ff & pm_sync_ff;
	assign armed_link    = cfg3_ff[0] & pwe_ff & pm_sync_ff;

	// ------------------------------------------------------------------------
	// Destination address check
	// ------------------------------------------------------------------------
	// Expected destination byte for the current header position
	always @* begin
		case (byte_idx_ff)
			4'h0: id_exp = node_id_ff[47:40];
			4'h1: id_exp = node_id_ff[39:32];
			4'h2: id_exp = node_id_ff[31:24];
			4'h3: id_exp = node_id_ff[23:16];
			4'h4: id_exp = node_id_ff[15:8];
			4'h5: id_exp = node_id_ff[7:0];
			default: id_exp = 8'h00;
		endcase
	end

	// Payload starts after destination and source addresses
	assign payload_byte = rx_valid & ~rx_sof & in_frame_ff &
		(byte_idx_ff == `WFLD_HDR_LEN);

	// Header counting and destination comparison
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_idx_ff  <= 4'h0;
			dst_own_ff   <= 1'b0;
			dst_mcast_ff <= 1'b0;
			in_frame_ff  <= 1'b0;
		end else if (rx_valid && rx_sof) begin
			// First destination byte carries the group bit
			in_frame_ff  <= 1'b1;
			byte_idx_ff  <= 4'h1;
			dst_own_ff   <= (rx_data == node_id_ff[47:40]);
			dst_mcast_ff <= rx_data[0];
		end else if (rx_eof) begin
			in_frame_ff <= 1'b0;
		end else if (rx_valid && in_frame_ff) begin
			if (byte_idx_ff < 4'h6)
				dst_own_ff <= dst_own_ff & (rx_data == id_exp);
			if (byte_idx_ff != `WFLD_HDR_LEN)
				byte_idx_ff <= byte_idx_ff + 4'h1;
		end
	end

	// ------------------------------------------------------------------------
	// Pattern scanner
	// ------------------------------------------------------------------------
	// Only payload bytes are fed, so headers never count toward the run
	wfld_pattern_scan u_scan (
		.clk         (pclk),
		.rst_n       (presetn),
		.frame_start (rx_valid & rx_sof),
		.byte_valid  (payload_byte & armed_pattern),
		.byte_data   (rx_data),
		.node_id     (node_id_ff),
		.found       (pattern_found)
	);

	// Frame qualifies: complete with good CRC, accepted address, full match.
	// The header counter at its end mark proves both addresses arrived.
	assign frame_ok = rx_eof & in_frame_ff & rx_crc_ok &
		(byte_idx_ff == `WFLD_HDR_LEN) &
		(dst_own_ff | dst_mcast_ff) &
		pattern_found & armed_pattern;

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	// Link and power state come from outside this clock domain
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_meta_ff <= 1'b0;
			link_sync_ff <= 1'b0;
			link_prev_ff <= 1'b0;
			pm_meta_ff   <= 1'b0;
			pm_sync_ff   <= 1'b0;
		end else begin
			link_meta_ff <= link_up_pin;
			link_sync_ff <= link_meta_ff;
			link_prev_ff <= link_sync_ff;
			pm_meta_ff   <= pm_state_ok;
			pm_sync_ff   <= pm_meta_ff;
		end
	end

	// Rising edge of the settled level means the cable came back
	assign link_rise = link_sync_ff & ~link_prev_ff & armed_link;

	assign events = {link_rise, frame_ok};

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	// Access completes on the second access cycle, when pready is high
	assign apb_access = psel & penable & pready_ff;
	assign apb_write  = apb_access & pwrite;
	assign mapped     = (paddr == `WFLD_OFS_CFG3) | (paddr == `WFLD_OFS_COMPANION) |
		(paddr == `WFLD_OFS_NODE_LO) | (paddr == `WFLD_OFS_NODE_HI) |
		(paddr == `WFLD_OFS_STATUS) | (paddr == `WFLD_OFS_CLEAR) |
		(paddr == `WFLD_OFS_ENABLE);
	assign clr_req    = (apb_write && paddr == `WFLD_OFS_CLEAR) ? pwdata[1:0] : 2'h0;

	// Bit 0 follows the PCI side; software writes to it are dropped
	assign cfg3_rd = {2'h0, cfg3_ff[1], cfg3_ff[0], 3'h0, fbb_ff};

	// Read data selection; clear register reads as zero
	always @* begin
		case (paddr)
			`WFLD_OFS_CFG3:      rd_mux = {24'h000000, cfg3_rd};
			`WFLD_OFS_COMPANION: rd_mux = {31'h00000000, pwe_ff};
			`WFLD_OFS_NODE_LO:   rd_mux = node_id_ff[31:0];
			`WFLD_OFS_NODE_HI:   rd_mux = {16'h0000, node_id_ff[47:32]};
			`WFLD_OFS_STATUS:    rd_mux = {30'h00000000, status_ff};
			`WFLD_OFS_ENABLE:    rd_mux = {30'h00000000, int_en_ff};
			default:             rd_mux = 32'h00000000;
		endcase
	end

	// ------------------------------------------------------------------------
	// APB handshake
	// ------------------------------------------------------------------------
	// One wait state keeps every bus output straight from a flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else if (psel && penable && !pready_ff) begin
			pready_ff  <= 1'b1;
			pslverr_ff <= ~mapped;
			prdata_ff  <= pwrite ? 32'h00000000 : rd_mux;
		end else begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end
	end

	// ------------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg3_ff    <= `WFLD_CFG3_RST;
			pwe_ff     <= `WFLD_COMP_RST;
			node_id_ff <= `WFLD_NODE_RST;
			int_en_ff  <= `WFLD_EVT_RST;
			fbb_ff     <= 1'b0;
		end else begin
			fbb_ff <= back_to_back_in;
			if (apb_write) begin
				case (paddr)
					`WFLD_OFS_CFG3: begin
						cfg3_ff <= {pwdata[`WFLD_CFG3_PATTERN], pwdata[`WFLD_CFG3_LINK]};
					end
					`WFLD_OFS_COMPANION: begin
						pwe_ff <= pwdata[`WFLD_COMP_PWE];
					end
					`WFLD_OFS_NODE_LO: begin
						node_id_ff[31:0] <= pwdata;
					end
					`WFLD_OFS_NODE_HI: begin
						node_id_ff[47:32] <= pwdata[15:0];
					end
					`WFLD_OFS_ENABLE: begin
						int_en_ff <= pwdata[1:0];
					end
					default: begin
						// Status and unmapped writes change nothing here
						int_en_ff <= int_en_ff;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Wake status, power event and interrupt
	// ------------------------------------------------------------------------
	// A set arriving with its clear wins, so no event is lost
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= `WFLD_EVT_RST;
			pme_n_ff  <= 1'b1;
			irq_ff    <= 1'b0;
		end else begin
			status_ff <= (status_ff & ~clr_req) | events;
			// Event output stays low until software clears the cause
			pme_n_ff  <= ~(|(((status_ff & ~clr_req) | events)));
			irq_ff    <= |(((status_ff & ~clr_req) | events) & int_en_ff);
		end
	end

endmodule // wfld_top

/* File: verification/wfld_props.sv */
`timescale 1ns/1ps
`include "wfld_map.vh"
// ----------------------------------------------------------------
// Port-level checks of the wake detector
// ----------------------------------------------------------------
module wfld_props (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        rx_eof,
	input wire        rx_crc_ok,
	input wire        link_up_pin,
	input wire        back_to_back_in,
	input wire        power_event_out_n,
	input wire        irq
);
	// A completed write to the clear register; the event output releases one edge after it
	wire clr_hit = psel && penable && pready && pwrite && (paddr == `WFLD_OFS_CLEAR);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	a_pready_access: assert property (pready |-> psel && penable && $past(psel) && $past(penable))
		else $error("pready outside a two-cycle access");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside the answer cycle");
	// Input equal to its values one, two and four edges back so the two register stages have caught up
	a_fbb_read: assert property (pready && !pwrite && paddr == `WFLD_OFS_CFG3 &&
		back_to_back_in == $past(back_to_back_in, 1) && back_to_back_in == $past(back_to_back_in, 2)
		&& back_to_back_in == $past(back_to_back_in, 4) |-> prdata[0] == back_to_back_in)
		else $error("back-to-back bit does not follow its input");
	a_pme_cause: assert property ($fell(power_event_out_n) && !link_up_pin |-> $past(rx_eof))
		else $error("pattern wake not one cycle after frame end");
	a_pme_hold: assert property (!power_event_out_n && !clr_hit && !$past(clr_hit, 1) &&
		!$past(clr_hit, 2) |=> !power_event_out_n)
		else $error("power event released without a clear");
	a_crc_block: assert property (rx_eof && !rx_crc_ok && power_event_out_n && !link_up_pin
		|=> power_event_out_n [*2])
		else $error("wake on a frame with bad check sequence");
	a_irq_pme: assert property (irq |-> !power_event_out_n)
		else $error("interrupt with no event pending");

	c_pattern_wake: cover property ($fell(power_event_out_n) && !link_up_pin);
	c_link_wake: cover property ($fell(power_event_out_n) && link_up_pin);
	c_irq: cover property ($rose(irq));
	c_slverr: cover property (pslverr);
endmodule // wfld_props

bind wfld_top wfld_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok), .link_up_pin(link_up_pin),
	.back_to_back_in(back_to_back_in), .power_event_out_n(power_event_out_n), .irq(irq));

/* File: verification/wfld_net_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Network side: frame byte source and cable link status
// ----------------------------------------------------------------
module wfld_net_model (
	input wire         pclk,
	output logic       rx_valid,
	output logic [7:0] rx_data,
	output logic       rx_sof,
	output logic       rx_eof,
	output logic       rx_crc_ok,
	output logic       link_up_pin
);
	logic [7:0] fq [$]; // Frame bytes queued by the bench

	// Idle lines at time zero, cable unplugged
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'hA5;
		rx_sof = 1'b0;
		rx_eof = 1'b0;
		rx_crc_ok = 1'b0;
		link_up_pin = 1'b0;
	end

	// Sends the queue as one frame; gap idle cycles between bytes models a slow source
	task automatic send(input bit crc, input int gap);
		int i;
		for (i = 0; i < fq.size(); i++) begin
			@(posedge pclk);
			rx_valid <= 1'b1;
			rx_data <= fq[i];
			rx_sof <= (i == 0);
			// Data not valid shows the inverse, never a stale copy
			repeat (gap) begin
				@(posedge pclk);
				rx_valid <= 1'b0;
				rx_sof <= 1'b0;
				rx_data <= ~fq[i];
			end
		end
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_sof <= 1'b0;
		// Inverse of the last byte, whatever the gap left on the lines
		rx_data <= ~fq[fq.size() - 1];
		rx_eof <= 1'b1;
		rx_crc_ok <= crc;
		@(posedge pclk);
		rx_eof <= 1'b0;
		rx_crc_ok <= ~crc;
		fq.delete();
	endtask

	// Cable plugged or pulled
	task automatic link(input bit up);
		@(posedge pclk);
		link_up_pin <= up;
	endtask
endmodule // wfld_net_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`include "wfld_map.vh"
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
	$display("wrong value at %0t: %s", $time, m); end end
// ----------------------------------------------------------------
// Bench for the wake detector
// ----------------------------------------------------------------
module testbench;
	// Driven inputs start from the initial blocks below, so no pin is tied
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pm_state_ok;
	logic        back_to_back_in;
	wire  [31:0] prdata;
	wire         pready, pslverr, rx_valid, rx_sof, rx_eof, rx_crc_ok, link_up_pin;
	wire  [7:0]  rx_data;
	wire         power_event_out_n, irq;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [31:0] rd;               // Last read data
	logic        err;              // Last error flag
	logic        irq_en = 1'b0;    // Interrupt enable the bench expects
	logic [7:0]  nid [6] = '{8'h02, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66}; // Group bit clear
	// kind(0 own,1 group,2 all-ones,3 other,4 no header) misc sync copies restart crc gap wake
	int tbl [10][8] = '{'{0,3,6,16,0,1,0,1}, '{0,0,7,16,0,1,1,1}, '{1,5,6,16,0,1,0,1},
		'{2,1,6,16,0,1,0,1}, '{3,3,6,16,0,1,0,0}, '{0,3,6,16,0,0,0,0}, '{1,3,6,15,0,1,0,0},
		'{0,3,5,16,0,1,0,0}, '{0,2,6,16,1,1,0,1}, '{4,0,6,16,0,1,0,0}};

	wfld_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
		.rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok), .link_up_pin(link_up_pin),
		.pm_state_ok(pm_state_ok), .back_to_back_in(back_to_back_in),
		.power_event_out_n(power_event_out_n), .irq(irq));
	wfld_net_model i_net (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
		.rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok), .link_up_pin(link_up_pin));

	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// Hang guard; the whole run needs well under a tenth of this
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, "run did not finish");
			conclude();
		end
	end

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One APB transfer; waits for pready without assuming its latency
	task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Builds, sends and judges one frame, then clears what it raised
	task automatic frame(input int kind, misc, nsync, ncp, rst, crc, gap, exp);
		int i, j;
		for (i = 0; i < 6 && kind != 4; i++) begin
			i_net.fq.push_back(kind == 0 ? nid[i] : kind == 1 ? (i == 0 ? 8'h01 : 8'h5E) :
				kind == 2 ? 8'hFF : nid[i] ^ 8'h0E);
		end
		for (i = 0; i < 6 && kind != 4; i++) i_net.fq.push_back(8'hA4);
		repeat (misc) i_net.fq.push_back(8'h5A);
		// Broken run: sync and two copies, cut by the next sync
		if (rst != 0) repeat (8) i_net.fq.push_back(8'hFF);
		if (rst != 0) repeat (2) for (j = 0; j < 6; j++) i_net.fq.push_back(nid[j]);
		repeat (nsync) i_net.fq.push_back(8'hFF);
		repeat (ncp) for (j = 0; j < 6; j++) i_net.fq.push_back(nid[j]);
		i_net.fq.push_back(8'h3C);
		i_net.send(crc[0], gap);
		repeat (3) @(posedge pclk);
		`CHK(power_event_out_n, ~exp[0], "power event after frame")
		`CHK(irq, exp[0] & irq_en, "interrupt after frame")
		apb(1'b0, `WFLD_OFS_STATUS, 32'h0);
		`CHK(rd, {31'h0, exp[0]}, "status after frame")
		apb(1'b1, `WFLD_OFS_CLEAR, 32'h3);
		repeat (3) @(posedge pclk);
		`CHK(power_event_out_n, 1'b1, "power event after clear")
		`CHK(irq, 1'b0, "interrupt after clear")
	endtask

	// Reset values, unmapped access, read-only bits
	task automatic t_regs();
		int a;
		for (a = 0; a <= 8'h18; a += 4) begin
			apb(1'b0, a[7:0], 32'h0);
			`CHK({err, rd}, 33'h0, "reset value")
		end
		apb(1'b0, 8'h1C, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0}, "unmapped access")
		back_to_back_in <= 1'b1;
		apb(1'b1, `WFLD_OFS_CFG3, 32'h30);
		apb(1'b0, `WFLD_OFS_CFG3, 32'h0);
		`CHK(rd, 32'h31, "config with back-to-back set")
		back_to_back_in <= 1'b0;
		apb(1'b1, `WFLD_OFS_CFG3, 32'h21);
		apb(1'b0, `WFLD_OFS_CFG3, 32'h0);
		`CHK(rd, 32'h20, "back-to-back bit not writable")
		apb(1'b1, `WFLD_OFS_NODE_HI, 32'h0222);
		apb(1'b1, `WFLD_OFS_NODE_LO, 32'h33445566);
		apb(1'b0, `WFLD_OFS_NODE_LO, 32'h0);
		`CHK(rd, 32'h33445566, "node id low")
		apb(1'b1, `WFLD_OFS_STATUS, 32'h3);
		apb(1'b0, `WFLD_OFS_STATUS, 32'h0);
		`CHK(rd, 32'h0, "status is read-only")
	endtask

	// Pattern cases from the table, then arming gates
	task automatic t_pattern();
		int k;
		apb(1'b1, `WFLD_OFS_COMPANION, 32'h1);
		for (k = 0; k < 10; k++) begin
			frame(tbl[k][0], tbl[k][1], tbl[k][2], tbl[k][3], tbl[k][4], tbl[k][5],
				tbl[k][6], tbl[k][7]);
		end
		apb(1'b1, `WFLD_OFS_COMPANION, 32'h0);
		frame(0, 3, 6, 16, 0, 1, 0, 0);
		apb(1'b1, `WFLD_OFS_COMPANION, 32'h1);
		apb(1'b1, `WFLD_OFS_CFG3, 32'h10);
		frame(0, 3, 6, 16, 0, 1, 0, 0);
		apb(1'b1, `WFLD_OFS_CFG3, 32'h20);
		pm_state_ok <= 1'b0;
		repeat (5) @(posedge pclk);
		frame(0, 3, 6, 16, 0, 1, 0, 0);
		pm_state_ok <= 1'b1;
		apb(1'b1, `WFLD_OFS_ENABLE, 32'h1);
		irq_en = 1'b1;
		frame(0, 4, 6, 16, 0, 1, 0, 1);
	endtask

	// Cable link restored under the global enable and link enable gates
	task automatic t_link();
		apb(1'b1, `WFLD_OFS_COMPANION, 32'h0);
		apb(1'b1, `WFLD_OFS_CFG3, 32'h10);
		i_net.link(1'b1);
		repeat (10) @(posedge pclk);
		`CHK(power_event_out_n, 1'b1, "link wake without global enable")
		i_net.link(1'b0);
		apb(1'b1, `WFLD_OFS_COMPANION, 32'h1);
		apb(1'b1, `WFLD_OFS_CFG3, 32'h20);
		i_net.link(1'b1);
		repeat (10) @(posedge pclk);
		`CHK(power_event_out_n, 1'b1, "link wake while disabled")
		i_net.link(1'b0);
		apb(1'b1, `WFLD_OFS_CFG3, 32'h10);
		i_net.link(1'b1);
		repeat (10) @(posedge pclk);
		`CHK({irq, power_event_out_n}, 2'h0, "link wake")
		apb(1'b0, `WFLD_OFS_STATUS, 32'h0);
		`CHK(rd, 32'h2, "link status")
	endtask

	// Main sequence
	initial begin
		// Bus idle, power state wake-capable, reset held
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h00000000;
		pm_state_ok <= 1'b1;
		back_to_back_in <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_pattern();
		t_link();
		conclude();
	end
endmodule // testbench
